//--- core/asm_core.v
// integer alu, status flags, 17x17 multiplier and iterative divider
// assumes an apb master on pclk and a sequencer driving repeat_active on pclk
//
// Function
// - status bits 7..5 hold the 3-bit cpu priority level 0..7.
// - level is high bit prefixed to field; user irqs blocked if high or 111.
// - priority field ignores writes while nesting disable is 1.
// - status bit 4 reads 1 while a repeat loop runs.
// - negative flag bit 3 set on negative result, else cleared.
// - overflow flag bit 2 set on signed overflow, else cleared.
// - zero flag bit 1 set on zero result; addc and subb only clear it on non-zero, else keep it.
// - carry flag bit 0 set on carry out of the msb.
// - data write changes both saturation flags, directly or by clearing combined.
// - 16-bit two's-complement alu adds, subtracts, shifts and does logic.
// - alu updates zero and negative flags; add and subtract also update carry, overflow and digit carry.
// - for subtraction carry and digit carry mean no borrow.
// - alu operations and the uu multiply run byte or word wide as the command selects.
// - operands and results use working registers or the memory data word.
// - multiply uses one 17x17 signed product for all signedness.
// - modes ss, uu, su, us, signed/unsigned by 5-bit literal, byte uu.
// - divide 32/16 and 16/16, signed and unsigned.
// - quotient goes to working register zero, remainder to one.
// - divisor from any register; long dividend from even/odd pair, odd high.
// - divide takes one cycle per divisor bit for both dividend sizes.
`timescale 1ns/1ns
`include "asm_map.vh"

module asm_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire repeat_active,
    output reg user_irq_blocked,
    output reg [3:0] cpu_priority,
    output reg busy
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_EXEC = 2'h1;
localparam [1:0] ST_DIV = 2'h2;
localparam [1:0] ST_DONE = 2'h3;

reg c_q, z_q, ov_q, n_q, ra_q, dc_q, sa_q, sb_q;
reg [2:0] ipl_q;
reg priority_level_high_bit_q, nstd_q;
reg [31:0] cmd_q;
reg [15:0] mem_q, reshi_q;
reg [15:0] wreg_q [0:15];
reg [1:0] state_q;
reg [15:0] rem_q, quo_q, dvs_q;
reg qneg_q, rneg_q, dovf_q;
reg [4:0] cnt_q;
integer i;

////////////////////////////////////////////////////////////////////////////
// apb decode; zero wait, answer registered at the setup edge
wire setup = psel & ~penable;
wire acc = psel & penable & pready;
wire wr = acc & pwrite & ~pslverr; // the error decided at setup also gates the write
wire aligned = (paddr[1:0] == 2'h0);
wire hit_st = aligned & (paddr == `ASM_OFF_STATUS);
wire hit_core = aligned & (paddr == `ASM_OFF_CORE);
wire hit_intc = aligned & (paddr == `ASM_OFF_INTC);
wire hit_cmd = aligned & (paddr == `ASM_OFF_CMD);
wire hit_mem = aligned & (paddr == `ASM_OFF_MEM);
wire hit_rhi = aligned & (paddr == `ASM_OFF_RESHI);
wire hit_w = aligned & (paddr[7:6] == `ASM_WREG_PAGE);
wire mapped = hit_st | hit_core | hit_intc | hit_cmd | hit_mem | hit_rhi | hit_w;
// operand writes while the engine runs would corrupt it, so they are refused
wire refuse = busy & pwrite & (hit_cmd | hit_mem | hit_w);
wire [3:0] widx = paddr[5:2];

reg [15:0] st_word;
reg [31:0] rd_mux;
always @* begin
    st_word = `ASM_RST16;
    st_word[`ASM_ST_C] = c_q;
    st_word[`ASM_ST_Z] = z_q;
    st_word[`ASM_ST_OV] = ov_q;
    st_word[`ASM_ST_N] = n_q;
    st_word[`ASM_ST_RA] = ra_q;
    st_word[`ASM_ST_IPL_HI:`ASM_ST_IPL_LO] = ipl_q;
    st_word[`ASM_ST_DC] = dc_q;
    st_word[`ASM_ST_SAB] = sa_q | sb_q;
    st_word[`ASM_ST_SB] = sb_q;
    st_word[`ASM_ST_SA] = sa_q;
    rd_mux = `ASM_RST32;
    if (hit_st) begin
        rd_mux[15:0] = st_word;
    end
    if (hit_core) begin
        rd_mux[`ASM_CORE_PRIORITY_LEVEL_HIGH_BIT] = priority_level_high_bit_q;
    end
    if (hit_intc) begin
        rd_mux[`ASM_INTC_NSTD] = nstd_q;
    end
    if (hit_cmd) begin
        rd_mux = cmd_q;
        rd_mux[31] = busy;
    end
    if (hit_mem) begin
        rd_mux[15:0] = mem_q;
    end
    if (hit_rhi) begin
        rd_mux[15:0] = reshi_q;
    end
    if (hit_w) begin
        rd_mux[15:0] = wreg_q[widx];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= `ASM_RST32;
    end else begin
        pready <= setup;
        pslverr <= setup & (~mapped | refuse);
        prdata <= (setup & ~pwrite) ? rd_mux : `ASM_RST32;
    end
end

////////////////////////////////////////////////////////////////////////////
// command fields and operands
wire [3:0] op = cmd_q[`ASM_CMD_OP_HI:`ASM_CMD_OP_LO];
wire byte_m = cmd_q[`ASM_CMD_BYTE];
wire [3:0] ra = cmd_q[`ASM_CMD_RA_HI:`ASM_CMD_RA_LO];
wire [3:0] rb = cmd_q[`ASM_CMD_RB_HI:`ASM_CMD_RB_LO];
wire [3:0] rd = cmd_q[`ASM_CMD_RD_HI:`ASM_CMD_RD_LO];
wire [4:0] lit = cmd_q[`ASM_CMD_LIT_HI:`ASM_CMD_LIT_LO];
wire [2:0] mm = cmd_q[`ASM_CMD_MM_HI:`ASM_CMD_MM_LO];
wire [15:0] opa = wreg_q[ra];
wire [15:0] opb = cmd_q[`ASM_CMD_BMEM] ? mem_q : wreg_q[rb];
wire [15:0] dold = cmd_q[`ASM_CMD_DMEM] ? mem_q : wreg_q[rd];

////////////////////////////////////////////////////////////////////////////
// alu: add/sub with flags, logic, shifts
reg [15:0] bo, r16, res;
reg cin, is_arith, is_sub, fc, fdc, fov, fn, fz;
reg [16:0] sw;
reg [8:0] sb9;
reg [4:0] nib;
reg [15:0] ax;
always @* begin
    is_sub = (op == `ASM_OP_SUB) | (op == `ASM_OP_SUBB);
    is_arith = (op == `ASM_OP_ADD) | (op == `ASM_OP_ADDC) | is_sub;
    bo = is_sub ? ~opb : opb;
    cin = (op == `ASM_OP_SUB) | (((op == `ASM_OP_ADDC) | (op == `ASM_OP_SUBB)) & c_q);
    sw = {1'b0, opa} + {1'b0, bo} + {16'h0000, cin};
    sb9 = {1'b0, opa[7:0]} + {1'b0, bo[7:0]} + {8'h00, cin};
    nib = {1'b0, opa[3:0]} + {1'b0, bo[3:0]} + {4'h0, cin};
    ax = byte_m ? {{8{opa[7]}}, opa[7:0]} : opa;
    case (op)
        `ASM_OP_ADD, `ASM_OP_ADDC, `ASM_OP_SUB, `ASM_OP_SUBB: r16 = sw[15:0];
        `ASM_OP_AND: r16 = opa & opb;
        `ASM_OP_IOR: r16 = opa | opb;
        `ASM_OP_XOR: r16 = opa ^ opb;
        `ASM_OP_SL: r16 = opa << opb[3:0];
        `ASM_OP_LSR: r16 = (byte_m ? {8'h00, opa[7:0]} : opa) >> opb[3:0];
        `ASM_OP_ASR: r16 = $signed(ax) >>> opb[3:0];
        default: r16 = `ASM_RST16;
    endcase
    // byte results keep the upper byte of the destination
    res = byte_m ? {dold[15:8], r16[7:0]} : r16;
    fn = byte_m ? r16[7] : r16[15];
    fz = byte_m ? (r16[7:0] == 8'h00) : (r16 == `ASM_RST16);
    fc = byte_m ? sb9[8] : sw[16];
    fdc = byte_m ? nib[4] : sb9[8];
    fov = byte_m ? ((opa[7] == bo[7]) & (r16[7] != opa[7])) :
        ((opa[15] == bo[15]) & (r16[15] != opa[15]));
end

////////////////////////////////////////////////////////////////////////////
// multiplier: one signed 17x17 product covers every mode
reg [16:0] mx, my;
reg [33:0] prod;
always @* begin
    case (mm)
        `ASM_MM_SS: begin
            mx = {opa[15], opa};
            my = {opb[15], opb};
        end
        `ASM_MM_SU: begin
            mx = {opa[15], opa};
            my = {1'b0, opb};
        end
        `ASM_MM_US: begin
            mx = {1'b0, opa};
            my = {opb[15], opb};
        end
        `ASM_MM_SL: begin
            mx = {opa[15], opa};
            my = {12'h000, lit};
        end
        `ASM_MM_UL: begin
            mx = {1'b0, opa};
            my = {12'h000, lit};
        end
        default: begin
            mx = byte_m ? {9'h000, opa[7:0]} : {1'b0, opa};
            my = byte_m ? {9'h000, opb[7:0]} : {1'b0, opb};
        end
    endcase
    prod = $signed(mx) * $signed(my);
end

////////////////////////////////////////////////////////////////////////////
// divider set-up: magnitudes and signs
wire dsgn = cmd_q[`ASM_CMD_SGN];
wire [3:0] ra_ev = {ra[3:1], 1'b0};
wire [3:0] ra_od = {ra[3:1], 1'b1};
wire [31:0] dvd = cmd_q[`ASM_CMD_LONG] ? {wreg_q[ra_od], wreg_q[ra_ev]} :
    {(dsgn ? {16{opa[15]}} : 16'h0000), opa};
wire dvd_neg = dsgn & dvd[31];
wire dvs_neg = dsgn & wreg_q[rb][15];
wire [31:0] dvd_mag = dvd_neg ? (32'h00000000 - dvd) : dvd;
wire [15:0] dvs_mag = dvs_neg ? (16'h0000 - wreg_q[rb]) : wreg_q[rb];
wire [16:0] shl = {rem_q, quo_q[15]};
wire [17:0] trial = {1'b0, shl} - {2'h0, dvs_q};
wire [15:0] qout = qneg_q ? (16'h0000 - quo_q) : quo_q;
wire [15:0] rout = rneg_q ? (16'h0000 - rem_q) : rem_q;

////////////////////////////////////////////////////////////////////////////
// sequencer, status register and working registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        c_q <= 1'b0;
        z_q <= 1'b0;
        ov_q <= 1'b0;
        n_q <= 1'b0;
        ra_q <= 1'b0;
        dc_q <= 1'b0;
        sa_q <= 1'b0;
        sb_q <= 1'b0;
        ipl_q <= 3'h0;
        priority_level_high_bit_q <= 1'b0;
        nstd_q <= 1'b0;
        cmd_q <= `ASM_RST32;
        mem_q <= `ASM_RST16;
        reshi_q <= `ASM_RST16;
        state_q <= ST_IDLE;
        busy <= 1'b0;
        rem_q <= `ASM_RST16;
        quo_q <= `ASM_RST16;
        dvs_q <= `ASM_RST16;
        qneg_q <= 1'b0;
        rneg_q <= 1'b0;
        dovf_q <= 1'b0;
        cnt_q <= 5'h00;
        user_irq_blocked <= 1'b0;
        cpu_priority <= 4'h0;
        for (i = 0; i < 16; i = i + 1) begin
            wreg_q[i] <= `ASM_RST16;
        end
    end else begin
        ra_q <= repeat_active;
        cpu_priority <= {priority_level_high_bit_q, ipl_q};
        user_irq_blocked <= priority_level_high_bit_q | (ipl_q == `ASM_IPL_MASKED);
        if (wr & hit_st) begin
            c_q <= pwdata[`ASM_ST_C];
            z_q <= pwdata[`ASM_ST_Z];
            ov_q <= pwdata[`ASM_ST_OV];
            n_q <= pwdata[`ASM_ST_N];
            dc_q <= pwdata[`ASM_ST_DC];
            if (!nstd_q) begin
                ipl_q <= pwdata[`ASM_ST_IPL_HI:`ASM_ST_IPL_LO];
            end
            // a zero in the combined bit clears both, else both take the data
            sa_q <= pwdata[`ASM_ST_SA] & pwdata[`ASM_ST_SAB];
            sb_q <= pwdata[`ASM_ST_SB] & pwdata[`ASM_ST_SAB];
        end
        if (wr & hit_core) begin
            priority_level_high_bit_q <= pwdata[`ASM_CORE_PRIORITY_LEVEL_HIGH_BIT];
        end
        if (wr & hit_intc) begin
            nstd_q <= pwdata[`ASM_INTC_NSTD];
        end
        if (wr & ~refuse & hit_mem) begin
            mem_q <= pwdata[15:0];
        end
        if (wr & ~refuse & hit_w) begin
            wreg_q[widx] <= pwdata[15:0];
        end
        if (wr & ~refuse & hit_cmd) begin
            cmd_q <= pwdata;
            state_q <= ST_EXEC;
            busy <= 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                if (op == `ASM_OP_DIV) begin
                    rem_q <= dvd_mag[31:16];
                    quo_q <= dvd_mag[15:0];
                    dvs_q <= dvs_mag;
                    qneg_q <= dvd_neg ^ dvs_neg;
                    rneg_q <= dvd_neg;
                    dovf_q <= (dvd_mag[31:16] >= dvs_mag);
                    cnt_q <= `ASM_DIV_STEPS;
                    state_q <= ST_DIV;
                end else if (op == `ASM_OP_MUL) begin
                    if (cmd_q[`ASM_CMD_DMEM]) begin
                        mem_q <= prod[15:0];
                    end else begin
                        wreg_q[rd] <= prod[15:0];
                    end
                    reshi_q <= prod[31:16];
                    state_q <= ST_IDLE;
                    busy <= 1'b0;
                end else begin
                    if (cmd_q[`ASM_CMD_DMEM]) begin
                        mem_q <= res;
                    end else begin
                        wreg_q[rd] <= res;
                    end
                    n_q <= fn;
                    if ((op == `ASM_OP_ADDC) | (op == `ASM_OP_SUBB)) begin
                        z_q <= z_q & fz;
                    end else begin
                        z_q <= fz;
                    end
                    if (is_arith) begin
                        c_q <= fc;
                        dc_q <= fdc;
                        ov_q <= fov;
                    end
                    state_q <= ST_IDLE;
                    busy <= 1'b0;
                end
            end
            ST_DIV: begin
                // restoring step, one quotient bit per cycle
                if (!trial[17]) begin
                    rem_q <= trial[15:0];
                    quo_q <= {quo_q[14:0], 1'b1};
                end else begin
                    rem_q <= shl[15:0];
                    quo_q <= {quo_q[14:0], 1'b0};
                end
                cnt_q <= cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    state_q <= ST_DONE;
                end
            end
            ST_DONE: begin
                wreg_q[0] <= qout;
                wreg_q[1] <= rout;
                n_q <= qout[15];
                z_q <= (qout == `ASM_RST16);
                ov_q <= dovf_q;
                state_q <= ST_IDLE;
                busy <= 1'b0;
            end
            default: begin
                state_q <= ST_IDLE;
                busy <= 1'b0;
            end
        endcase
    end
end

endmodule // asm_core

//--- core/asm_map.vh
// register offsets, field positions, reset values and counts of the
// alu/status/muldiv block; included by the core, holds definitions only
`ifndef ASM_MAP_VH
`define ASM_MAP_VH
`define ASM_OFF_STATUS 8'h00
`define ASM_OFF_CORE 8'h04
`define ASM_OFF_INTC 8'h08
`define ASM_OFF_CMD 8'h0C
`define ASM_OFF_MEM 8'h10
`define ASM_OFF_RESHI 8'h14
`define ASM_WREG_PAGE 2'h1
`define ASM_RST16 16'h0000
`define ASM_RST32 32'h00000000
`define ASM_ST_C 0
`define ASM_ST_Z 1
`define ASM_ST_OV 2
`define ASM_ST_N 3
`define ASM_ST_RA 4
`define ASM_ST_IPL_LO 5
`define ASM_ST_IPL_HI 7
`define ASM_ST_DC 8
`define ASM_ST_SAB 10
`define ASM_ST_SB 12
`define ASM_ST_SA 13
`define ASM_CORE_PRIORITY_LEVEL_HIGH_BIT 3
`define ASM_INTC_NSTD 15
`define ASM_IPL_MASKED 3'h7
`define ASM_CMD_OP_HI 3
`define ASM_CMD_OP_LO 0
`define ASM_CMD_BYTE 4
`define ASM_CMD_BMEM 5
`define ASM_CMD_DMEM 6
`define ASM_CMD_RA_HI 11
`define ASM_CMD_RA_LO 8
`define ASM_CMD_RB_HI 15
`define ASM_CMD_RB_LO 12
`define ASM_CMD_RD_HI 19
`define ASM_CMD_RD_LO 16
`define ASM_CMD_LIT_HI 24
`define ASM_CMD_LIT_LO 20
`define ASM_CMD_LONG 28
`define ASM_CMD_SGN 29
`define ASM_CMD_MM_HI 30
`define ASM_CMD_MM_LO 28
`define ASM_OP_ADD 4'h0
`define ASM_OP_ADDC 4'h1
`define ASM_OP_SUB 4'h2
`define ASM_OP_SUBB 4'h3
`define ASM_OP_AND 4'h4
`define ASM_OP_IOR 4'h5
`define ASM_OP_XOR 4'h6
`define ASM_OP_SL 4'h7
`define ASM_OP_LSR 4'h8
`define ASM_OP_ASR 4'h9
`define ASM_OP_MUL 4'hA
`define ASM_OP_DIV 4'hB
`define ASM_MM_SS 3'h0
`define ASM_MM_UU 3'h1
`define ASM_MM_SU 3'h2
`define ASM_MM_US 3'h3
`define ASM_MM_SL 3'h4
`define ASM_MM_UL 3'h5
`define ASM_DIV_STEPS 5'h10
`endif

//--- testbench/asm_chk.sv
// assertions on the apb, priority and busy ports of asm_core
// assumes one pclk domain with presetn active low
`timescale 1ns/1ns
module asm_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire repeat_active,
    input wire user_irq_blocked,
    input wire [3:0] cpu_priority,
    input wire busy
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
wire wok = psel && penable && pready && pwrite && !pslverr;
reg nstd_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) nstd_q <= 1'b0;
    else if (wok && paddr == 8'h08) nstd_q <= pwdata[15];
end
////////////////////////////////////////
property p_rdy; psel && !penable |=> pready; endproperty
a_rdy: assert property (p_rdy) else $error("ready missing");
property p_idle; !(psel && penable) |-> !pready && prdata == 32'h0; endproperty
a_idle: assert property (p_idle) else $error("idle bus");
property p_blk; user_irq_blocked == (cpu_priority[3] || cpu_priority[2:0] == 3'h7); endproperty
a_blk: assert property (p_blk) else $error("blocking wrong");
property p_iplw; wok && paddr == 8'h00 && !nstd_q |-> ##2 cpu_priority[2:0] == $past(pwdata[7:5], 2); endproperty
a_iplw: assert property (p_iplw) else $error("level write");
property p_iplro; wok && paddr == 8'h00 && nstd_q |-> ##2 cpu_priority[2:0] == $past(cpu_priority[2:0], 2); endproperty
a_iplro: assert property (p_iplro) else $error("level changed");
property p_priority_level_high_bit; wok && paddr == 8'h04 |-> ##2 cpu_priority[3] == $past(pwdata[3], 2); endproperty
a_priority_level_high_bit: assert property (p_priority_level_high_bit) else $error("high bit");
property p_alu; wok && paddr == 8'h0C && pwdata[3:0] != 4'hB |=> busy ##1 !busy; endproperty
a_alu: assert property (p_alu) else $error("alu busy");
property p_div; wok && paddr == 8'h0C && pwdata[3:0] == 4'hB |=> busy ##17 busy ##1 !busy; endproperty
a_div: assert property (p_div) else $error("divide length");
endmodule // asm_chk
bind asm_core asm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .repeat_active(repeat_active), .user_irq_blocked(user_irq_blocked),
    .cpu_priority(cpu_priority), .busy(busy));

//--- testbench/asm_core_tb.sv
// self-checking bench for asm_core, one task per scenario over apb
// assumes asm_chk bound to the core and asm_seq_model on repeat_active
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
$display("Error at %0t: got %h expected %h", $time, g, e); end end
module asm_core_tb;
reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
reg [7:0] paddr = 8'h00;
reg [31:0] pwdata = 32'h0, rdata;
wire [31:0] prdata;
wire pready, pslverr, repeat_active, user_irq_blocked, busy;
wire [3:0] cpu_priority;
integer miscompares = 0, samples_checked = 0, n1, n2, i;
reg err;
reg [15:0] a, b, e, msk;
reg signed [33:0] p;
asm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .repeat_active(repeat_active), .user_irq_blocked(user_irq_blocked),
    .cpu_priority(cpu_priority), .busy(busy));
asm_seq_model seq (.pclk(pclk), .presetn(presetn), .start(start), .count(8'h14),
    .repeat_active(repeat_active));
initial forever #10 pclk = ~pclk;
initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    $display("Error at %0t: timeout", $time);
    stop_test;
end
task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
////////////////////////////////////////
task xfer(input w, input [7:0] ad, input [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {err, rdata} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
endtask
task wr(input [7:0] ad, input [31:0] d);
    xfer(1'b1, ad, d);
endtask
task rd(input [7:0] ad);
    xfer(1'b0, ad, 32'h0);
endtask
task waitb(output integer n);
    n = 0;
    do begin
        @(posedge pclk);
        n++;
    end while (busy === 1'b1 && n < 40);
endtask
task go(input [31:0] c, output integer n);
    wr(8'h0C, c);
    waitb(n);
endtask
////////////////////////////////////////
task t_arith;
    wr(8'h48, 32'h5);
    wr(8'h4C, 32'h5);
    go(32'h0004_3202, n1);
    rd(8'h00);
    `CHK(rdata, 32'h103)
    wr(8'h48, 32'h7FFF);
    wr(8'h4C, 32'h1);
    go(32'h0004_3200, n1);
    rd(8'h50);
    `CHK(rdata, 32'h8000)
    rd(8'h00);
    `CHK(rdata, 32'h10C)
    wr(8'h48, 32'h12FF);
    go(32'h0004_3210, n1);
    rd(8'h50);
    `CHK(rdata, 32'h80FF & 32'hFF00)
    rd(8'h00);
    `CHK(rdata, 32'h103)
endtask
task t_carry;
    wr(8'h00, 32'h3);
    wr(8'h10, 32'h55);
    wr(8'h48, 32'hFFFF);
    wr(8'h4C, 32'h0);
    go(32'h0004_3241, n1);
    rd(8'h10);
    `CHK(rdata, 32'h0)
    rd(8'h00);
    `CHK(rdata, 32'h103)
    wr(8'h10, 32'h1);
    wr(8'h48, 32'h5);
    go(32'h0004_3223, n1);
    rd(8'h50);
    `CHK(rdata, 32'h4)
    rd(8'h00);
    `CHK(rdata, 32'h101)
    wr(8'h10, 32'h0);
    wr(8'h48, 32'hFFFF);
    go(32'h0004_3221, n1);
    rd(8'h00);
    `CHK(rdata, 32'h101)
    wr(8'h10, 32'h2);
    wr(8'h48, 32'h1);
    go(32'h0004_3222, n1);
    rd(8'h50);
    `CHK(rdata, 32'hFFFF)
    rd(8'h00);
    `CHK(rdata, 32'h8)
endtask
task t_logic;
    a = 16'h8421;
    wr(8'h48, 32'h8421);
    wr(8'h4C, 32'h4);
    for (i = 4; i < 10; i++) begin
        case (i)
            4: e = a & 16'h4;
            5: e = a | 16'h4;
            6: e = a ^ 16'h4;
            7: e = a << 4;
            8: e = a >> 4;
            default: e = $signed(a) >>> 4;
        endcase
        go(32'h0004_3200 | i, n1);
        rd(8'h50);
        `CHK(rdata[15:0], e)
    end
endtask
task t_mul;
    wr(8'h48, 32'hFFFE);
    wr(8'h4C, 32'hFFFD);
    for (i = 0; i < 7; i++) begin
        a = (i == 6) ? 16'h00FE : 16'hFFFE;
        b = (i == 6) ? 16'h00FD : (i > 3) ? 16'h0005 : 16'hFFFD;
        p = $signed({a[15] & (i == 0 || i == 2 || i == 4), a})
            * $signed({b[15] & (i == 0 || i == 3), b});
        msk = (i == 6) ? 16'h00FF : 16'hFFFF;
        go(32'h0054_320A | ((i == 6) ? 32'h1000_0010 : i << 28), n1);
        rd(8'h50);
        `CHK(rdata[15:0] & msk, p[15:0] & msk)
        rd(8'h14);
        `CHK(rdata[15:0], p[31:16])
    end
endtask
task t_div;
    wr(8'h48, 32'hFFF9);
    wr(8'h4C, 32'h2);
    go(32'h2000_320B, n1);
    rd(8'h40);
    `CHK(rdata, 32'hFFFD)
    rd(8'h44);
    `CHK(rdata, 32'hFFFF)
    wr(8'h58, 32'h5);
    wr(8'h5C, 32'h1);
    wr(8'h4C, 32'h4);
    go(32'h1000_360B, n2);
    rd(8'h40);
    `CHK(rdata, 32'h4001)
    rd(8'h44);
    `CHK(rdata, 32'h1)
    `CHK(n1, 19)
    `CHK(n2, n1)
    wr(8'h0C, 32'h3000_360B);
    wr(8'h54, 32'h7);
    `CHK(err, 1'b1)
    waitb(n1);
    rd(8'h54);
    `CHK(rdata, 32'h0)
endtask
task t_status;
    wr(8'h00, 32'h3400);
    rd(8'h00);
    `CHK(rdata & 32'h3400, 32'h3400)
    wr(8'h00, 32'h3000);
    rd(8'h00);
    `CHK(rdata & 32'h3400, 32'h0)
    wr(8'h00, 32'hE0);
    rd(8'h00);
    `CHK(rdata[7:5], 3'h7)
    `CHK(user_irq_blocked, 1'b1)
    wr(8'h00, 32'h60);
    wr(8'h04, 32'h8);
    rd(8'h04);
    `CHK(cpu_priority, 4'hB)
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h8000);
    `CHK(user_irq_blocked, 1'b0)
    wr(8'h00, 32'hE0);
    rd(8'h00);
    `CHK(rdata[7:5], 3'h3)
    wr(8'h08, 32'h0);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    rd(8'h00);
    `CHK(rdata[4], 1'b1)
    repeat (24) @(posedge pclk);
    rd(8'h00);
    `CHK(rdata[4], 1'b0)
    rd(8'h20);
    `CHK({err, rdata}, 33'h1_0000_0000)
endtask
initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00);
    `CHK({cpu_priority, rdata}, 36'h0)
    t_arith;
    t_carry;
    t_logic;
    t_mul;
    t_div;
    t_status;
    stop_test;
end
endmodule // asm_core_tb

//--- testbench/asm_seq_model.sv
// sequencer stand-in: holds repeat_active for count cycles after start
// assumes start is a one-cycle pulse on pclk
`timescale 1ns/1ns
module asm_seq_model (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire [7:0] count,
    output wire repeat_active
);
reg [7:0] left_q;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) left_q <= 8'h00;
    else if (start) left_q <= count;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
end
assign repeat_active = left_q != 8'h00;
endmodule // asm_seq_model
